// ==== design/motion_cfg_pkg.sv ====
package motion_cfg_pkg;
   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_RATE_DIVIDER = 8'h19;
   localparam logic [7:0] IDX_FIFO_SYNC_FILTER = 8'h1A;
   localparam logic [7:0] IDX_GYRO_RANGE = 8'h1B;
   localparam logic [7:0] IDX_ACCEL_RANGE = 8'h1C;
   localparam logic [7:0] IDX_ACCEL_FILTER = 8'h1D;
   localparam logic [7:0] IDX_STATUS = 8'h3E;
   // ==========================================================
   // writable bit masks and reset values
   localparam logic [7:0] MASK_FIFO_SYNC_FILTER = 8'h7F;
   localparam logic [7:0] MASK_GYRO_RANGE = 8'hFB;
   localparam logic [7:0] MASK_ACCEL_RANGE = 8'hF8;
   localparam logic [7:0] MASK_ACCEL_FILTER = 8'h0F;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   // ==========================================================
   // field positions
   localparam int FIFO_POLICY_BIT = 6;
   localparam int SYNC_SEL_LSB = 3;
   localparam int GYRO_FILT_LSB = 0;
   localparam int SELFTEST_LSB = 5;
   localparam int RANGE_LSB = 3;
   localparam int GYRO_BYPASS_LSB = 0;
   localparam int ACCEL_BYPASS_BIT = 3;
   localparam int ACCEL_FILT_LSB = 0;
   // ==========================================================
   // timing at a 40 MHz clock
   localparam int CLK_PERIOD_NS = 25;
   localparam int PERIOD_32K_NS = 31250;
   localparam int PERIOD_8K_NS = 125000;
   localparam int PERIOD_4K_NS = 250000;
   localparam int PERIOD_1K_NS = 1000000;
   localparam int CYC_32K = PERIOD_32K_NS / CLK_PERIOD_NS;
   localparam int CYC_8K = PERIOD_8K_NS / CLK_PERIOD_NS;
   localparam int CYC_4K = PERIOD_4K_NS / CLK_PERIOD_NS;
   localparam int CYC_1K = PERIOD_1K_NS / CLK_PERIOD_NS;
   // ==========================================================
   // bus answers and internal rates
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {RATE_32K, RATE_8K, RATE_4K, RATE_1K} rate_t;
endpackage : motion_cfg_pkg

// ==== design/sample_fifo_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic sys_clk,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk)
   begin
      if (ce && wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (ce && rd_en)
      begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : sample_fifo_mem
`default_nettype wire

// ==== design/motion_sensor_filter_config.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// - policy one and full: drop new samples
// - policy zero and full: overwrite oldest
// - sync field zero disables sync capture
// - sync replaces bit0 of chosen channel
// - sync latch toggles once per strobe
// - gyro filter used only when bypass zero
// - filter choice is inverted bypass field
// - gyro rate 32k, 8k or 1k
// - gyro range 250 to 2000 dps
// - accel range 2 to 16 g
// - gyro bypass field in bits 1:0
// - accel bypass bit at bit 3
// - accel filter setting in bits 2:0
// - divider only when choice 11, 0<setting<7
// - accel 4k when bypassed, else 1k
module motion_sensor_filter_config
   import motion_cfg_pkg::*;
#(
   parameter int ADDR_W = 10,
   parameter int FIFO_DEPTH = 16,
   parameter int FIFO_AW = 4,
   parameter int CNT_W = 20,
   parameter int CYC_8K_P = motion_cfg_pkg::CYC_8K,
   parameter int CYC_4K_P = motion_cfg_pkg::CYC_4K,
   parameter int CYC_1K_P = motion_cfg_pkg::CYC_1K
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic frame_sync_in,
   input wire logic sensor_valid,
   input wire logic [2:0] sensor_chan,
   input wire logic [7:0] sensor_low_byte,
   input wire logic drain_req,
   output logic [7:0] drain_data,
   output logic drain_valid,
   output logic sample_strobe,
   output logic accel_strobe,
   output motion_cfg_pkg::rate_t gyro_rate,
   output motion_cfg_pkg::rate_t accel_rate,
   output logic gyro_filter_used,
   output logic [11:0] gyro_fs_dps,
   output logic [4:0] accel_fs_g,
   output logic [5:0] selftest_en
);
   import motion_cfg_pkg::*;

   // ==========================================================
   // helpers
   function automatic rate_t gyro_rate_of(input logic [1:0] byp, input logic [2:0] set);
      if (byp != 2'b00)
         gyro_rate_of = RATE_32K;
      else if (set == 3'h0 || set == 3'h7)
         gyro_rate_of = RATE_8K;
      else
         gyro_rate_of = RATE_1K;
   endfunction : gyro_rate_of

   function automatic logic [CNT_W-1:0] period_of(input rate_t r);
      unique case (r)
         RATE_32K: period_of = CNT_W'(CYC_32K);
         RATE_8K: period_of = CNT_W'(CYC_8K_P);
         RATE_4K: period_of = CNT_W'(CYC_4K_P);
         RATE_1K: period_of = CNT_W'(CYC_1K_P);
      endcase
   endfunction : period_of

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction : hit

   // ==========================================================
   // registers
   logic [7:0] div_r, cfg_r, gyro_cfg_r, accel_cfg_r, accel2_r;
   logic [FIFO_AW:0] count_r;
   logic sync_capt_r;
   logic [1:0] gyro_bypass;
   logic [1:0] gyro_choice;
   logic [2:0] gyro_setting, sync_sel;
   logic fifo_policy;

   assign gyro_bypass = gyro_cfg_r[GYRO_BYPASS_LSB +: 2];
   assign gyro_choice = ~gyro_bypass;
   assign gyro_setting = cfg_r[GYRO_FILT_LSB +: 3];
   assign sync_sel = cfg_r[SYNC_SEL_LSB +: 3];
   assign fifo_policy = cfg_r[FIFO_POLICY_BIT];

   // ==========================================================
   // axi4-lite write channel
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wdata_r;
   logic wlane_r, aw_held_r, w_held_r, do_write, wr_ok;

   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_ok = hit(awaddr_r, IDX_RATE_DIVIDER) || hit(awaddr_r, IDX_FIFO_SYNC_FILTER)
      || hit(awaddr_r, IDX_GYRO_RANGE) || hit(awaddr_r, IDX_ACCEL_RANGE)
      || hit(awaddr_r, IDX_ACCEL_FILTER) || hit(awaddr_r, IDX_STATUS);

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 8'h00;
         wlane_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
         end
         else if (do_write)
            w_held_r <= 1'b0;
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else if (ce)
      begin
         s_axi_awready <= !(aw_held_r || (s_axi_awvalid && s_axi_awready)) || do_write;
         s_axi_wready <= !(w_held_r || (s_axi_wvalid && s_axi_wready)) || do_write;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         div_r <= RST_CONFIG;
         cfg_r <= RST_CONFIG;
         gyro_cfg_r <= RST_CONFIG;
         accel_cfg_r <= RST_CONFIG;
         accel2_r <= RST_CONFIG;
      end
      else if (ce && do_write && wlane_r)
      begin
         if (hit(awaddr_r, IDX_RATE_DIVIDER))
            div_r <= wdata_r;
         if (hit(awaddr_r, IDX_FIFO_SYNC_FILTER))
            cfg_r <= wdata_r & MASK_FIFO_SYNC_FILTER;
         if (hit(awaddr_r, IDX_GYRO_RANGE))
            gyro_cfg_r <= wdata_r & MASK_GYRO_RANGE;
         if (hit(awaddr_r, IDX_ACCEL_RANGE))
            accel_cfg_r <= wdata_r & MASK_ACCEL_RANGE;
         if (hit(awaddr_r, IDX_ACCEL_FILTER))
            accel2_r <= wdata_r & MASK_ACCEL_FILTER;
      end
   end

   // ==========================================================
   // axi4-lite read channel
   logic [31:0] rd_mux;
   logic rd_ok;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      if (hit(s_axi_araddr, IDX_RATE_DIVIDER))
         rd_mux[7:0] = div_r;
      else if (hit(s_axi_araddr, IDX_FIFO_SYNC_FILTER))
         rd_mux[7:0] = cfg_r;
      else if (hit(s_axi_araddr, IDX_GYRO_RANGE))
         rd_mux[7:0] = gyro_cfg_r;
      else if (hit(s_axi_araddr, IDX_ACCEL_RANGE))
         rd_mux[7:0] = accel_cfg_r;
      else if (hit(s_axi_araddr, IDX_ACCEL_FILTER))
         rd_mux[7:0] = accel2_r;
      else if (hit(s_axi_araddr, IDX_STATUS))
         rd_mux[15:0] = {3'h0, sync_capt_r, gyro_rate, accel_rate, 3'h0, count_r};
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (ce)
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // rate decode and config outputs
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gyro_rate <= RATE_32K;
         accel_rate <= RATE_32K;
         gyro_filter_used <= 1'b0;
         gyro_fs_dps <= 12'h000;
         accel_fs_g <= 5'h00;
         selftest_en <= 6'h00;
      end
      else if (ce)
      begin
         gyro_rate <= gyro_rate_of(gyro_bypass, gyro_setting);
         accel_rate <= accel2_r[ACCEL_BYPASS_BIT] ? RATE_4K : RATE_1K;
         gyro_filter_used <= (gyro_choice == 2'b11);
         gyro_fs_dps <= 12'(12'd250 << gyro_cfg_r[RANGE_LSB +: 2]);
         accel_fs_g <= 5'(5'd2 << accel_cfg_r[RANGE_LSB +: 2]);
         selftest_en <= {gyro_cfg_r[SELFTEST_LSB +: 3], accel_cfg_r[SELFTEST_LSB +: 3]};
      end
   end

   // ==========================================================
   // internal rate ticks and output sample strobe
   logic [CNT_W-1:0] gyro_cnt_r, accel_cnt_r;
   logic [7:0] div_cnt_r;
   logic int_tick, div_applies;

   assign int_tick = (gyro_cnt_r >= period_of(gyro_rate) - CNT_W'(1));
   assign div_applies = (gyro_choice == 2'b11) && (gyro_setting != 3'h0)
      && (gyro_setting != 3'h7);

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gyro_cnt_r <= '0;
         div_cnt_r <= 8'h00;
         sample_strobe <= 1'b0;
      end
      else if (ce)
      begin
         gyro_cnt_r <= int_tick ? '0 : gyro_cnt_r + CNT_W'(1);
         sample_strobe <= 1'b0;
         if (int_tick)
         begin
            if (!div_applies || div_cnt_r >= div_r)
            begin
               div_cnt_r <= 8'h00;
               sample_strobe <= 1'b1;
            end
            else
               div_cnt_r <= div_cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         accel_cnt_r <= '0;
         accel_strobe <= 1'b0;
      end
      else if (ce)
      begin
         accel_strobe <= (accel_cnt_r >= period_of(accel_rate) - CNT_W'(1));
         accel_cnt_r <= (accel_cnt_r >= period_of(accel_rate) - CNT_W'(1)) ? '0
            : accel_cnt_r + CNT_W'(1);
      end
   end

   // ==========================================================
   // frame sync synchroniser and toggle latch
   logic sync_meta_r, sync_s_r, latch_r, lock_r, toggle_now;

   assign toggle_now = (sync_s_r != latch_r) && !lock_r && (sync_sel != 3'h0);

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync_meta_r <= 1'b0;
         sync_s_r <= 1'b0;
         latch_r <= 1'b0;
         lock_r <= 1'b0;
         sync_capt_r <= 1'b0;
      end
      else if (ce)
      begin
         sync_meta_r <= frame_sync_in;
         sync_s_r <= sync_meta_r;
         latch_r <= latch_r ^ toggle_now;
         if (toggle_now)
            lock_r <= 1'b1;
         else if (sample_strobe)
            lock_r <= 1'b0;
         if (sample_strobe)
            sync_capt_r <= latch_r;
      end
   end

   // ==========================================================
   // sample fifo with overflow policy
   logic [FIFO_AW-1:0] wr_ptr_r, rd_ptr_r;
   logic [7:0] push_data;
   logic full, empty, pop, push_store;

   assign full = (count_r == (FIFO_AW+1)'(FIFO_DEPTH));
   assign empty = (count_r == '0);
   assign pop = drain_req && !empty;
   assign push_store = sensor_valid && !(full && fifo_policy && !pop);

   always_comb
   begin
      push_data = sensor_low_byte;
      if (sync_sel != 3'h0 && sensor_chan == sync_sel - 3'h1)
         push_data[0] = sync_capt_r;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else if (ce)
      begin
         if (push_store)
            wr_ptr_r <= wr_ptr_r + FIFO_AW'(1);
         if (pop || (push_store && full))
            rd_ptr_r <= rd_ptr_r + FIFO_AW'(1);
         if (push_store && !pop && !full)
            count_r <= count_r + (FIFO_AW+1)'(1);
         else if (pop && !push_store)
            count_r <= count_r - (FIFO_AW+1)'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         drain_valid <= 1'b0;
      else if (ce)
         drain_valid <= pop;
   end

   sample_fifo_mem #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_mem (
      .sys_clk(sys_clk),
      .ce(ce),
      .wr_en(push_store),
      .wr_addr(wr_ptr_r),
      .wr_data(push_data),
      .rd_en(pop),
      .rd_addr(rd_ptr_r),
      .rd_data(drain_data)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence full_push_s;
      ce && full && sensor_valid && !drain_req;
   endsequence

   chk_drop_when_full: assert property (full_push_s and fifo_policy |=>
      $stable(wr_ptr_r) && $stable(count_r))
      else $error("full fifo accepted a sample under drop policy");
   chk_overwrite_oldest: assert property (full_push_s and !fifo_policy |=>
      full && rd_ptr_r == $past(rd_ptr_r) + FIFO_AW'(1))
      else $error("full fifo did not overwrite oldest entry");
   chk_sync_off: assert property (sync_sel == 3'h0 && sensor_valid |->
      push_data == sensor_low_byte && !toggle_now)
      else $error("sync altered data while disabled");
   chk_sync_insert: assert property (sync_sel != 3'h0 && sensor_chan == sync_sel - 3'h1
      |-> push_data == {sensor_low_byte[7:1], sync_capt_r})
      else $error("sync bit not placed in chosen sample");

   sequence locked_s;
      ce && lock_r && !sample_strobe;
   endsequence

   chk_latch_hold: assert property (locked_s |=> $stable(latch_r))
      else $error("sync latch toggled twice between strobes");
   chk_filter_used: assert property (ce && rstn && gyro_bypass == 2'b00
      |=> gyro_filter_used)
      else $error("filter not used with bypass clear");
   chk_choice_inv: assert property (ce && gyro_bypass == 2'b11 |=> !gyro_filter_used)
      else $error("filter used with choice zero");
   chk_gyro_rate: assert property (ce && gyro_bypass != 2'b00 |=> gyro_rate == RATE_32K)
      else $error("gyro rate not 32k under bypass");
   chk_gyro_range: assert property (ce && gyro_cfg_r[4:3] == 2'b11 |=> gyro_fs_dps == 12'h7D0)
      else $error("gyro range not 2000");
   chk_accel_range: assert property (ce && accel_cfg_r[4:3] == 2'b10 |=> accel_fs_g == 5'h08)
      else $error("accel range not 8");
   chk_div_skip: assert property (ce && int_tick && !div_applies |=> sample_strobe)
      else $error("divider applied outside its window");
   chk_accel_rate: assert property (ce && accel2_r[3] |=> accel_rate == RATE_4K)
      else $error("accel rate not 4k under bypass");
   chk_reserved_zero: assert property (cfg_r[7] == 1'b0 && gyro_cfg_r[2] == 1'b0
      && accel2_r[7:4] == 4'h0)
      else $error("reserved bit holds a one");
endmodule : motion_sensor_filter_config
`default_nettype wire

// ==== tb/sensor_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module sensor_source (
   input wire logic sys_clk,
   output logic sensor_valid,
   output logic [2:0] sensor_chan,
   output logic [7:0] sensor_low_byte,
   output logic frame_sync_in
);
   // ==========================================================
   // idle state
   initial
   begin
      sensor_valid = 1'b0;
      sensor_chan = 3'h0;
      sensor_low_byte = 8'h00;
      frame_sync_in = 1'b0;
   end
   // ==========================================================
   // one sample byte, released lines show the inverse
   task automatic push(input logic [2:0] c, input logic [7:0] d);
      @(posedge sys_clk);
      sensor_valid <= 1'b1;
      sensor_chan <= c;
      sensor_low_byte <= d;
      @(posedge sys_clk);
      sensor_valid <= 1'b0;
      sensor_chan <= ~c;
      sensor_low_byte <= ~d;
   endtask : push
   // short frame-sync strobe of n cycles
   task automatic sync_pulse(input int n);
      @(posedge sys_clk);
      frame_sync_in <= 1'b1;
      repeat (n) @(posedge sys_clk);
      frame_sync_in <= 1'b0;
   endtask : sync_pulse
endmodule : sensor_source
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import motion_cfg_pkg::*;
   localparam logic [9:0] A_DIV = {IDX_RATE_DIVIDER, 2'b00};
   localparam logic [9:0] A_CFG = {IDX_FIFO_SYNC_FILTER, 2'b00};
   localparam logic [9:0] A_GYR = {IDX_GYRO_RANGE, 2'b00};
   localparam logic [9:0] A_ACC = {IDX_ACCEL_RANGE, 2'b00};
   localparam logic [9:0] A_AFL = {IDX_ACCEL_FILTER, 2'b00};
   localparam logic [9:0] A_STA = {IDX_STATUS, 2'b00};
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [9:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [9:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic drain_req = 1'b0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic frame_sync_in, sensor_valid, drain_valid, sample_strobe, accel_strobe;
   wire logic [2:0] sensor_chan;
   wire logic [7:0] sensor_low_byte, drain_data;
   rate_t gyro_rate, accel_rate;
   wire logic gyro_filter_used;
   wire logic [11:0] gyro_fs_dps;
   wire logic [4:0] accel_fs_g;
   wire logic [5:0] selftest_en;
   int failures = 0;
   int tests_run = 0;
   logic [31:0] d;
   logic [1:0] r;
   int p;
   rate_t t_rate [7] = '{RATE_32K, RATE_32K, RATE_32K, RATE_8K, RATE_8K, RATE_1K, RATE_8K};
   logic [7:0] t_cfg [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h03, 8'h00};
   logic [7:0] t_byp [7] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [6:0] t_used = 7'b1111000;

   always #12.5 sys_clk = ~sys_clk;

   motion_sensor_filter_config #(.CYC_8K_P(40), .CYC_4K_P(30), .CYC_1K_P(60))
   i_motion_sensor_filter_config (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_sync_in(frame_sync_in),
      .sensor_valid(sensor_valid), .sensor_chan(sensor_chan), .sensor_low_byte(sensor_low_byte),
      .drain_req(drain_req), .drain_data(drain_data), .drain_valid(drain_valid),
      .sample_strobe(sample_strobe), .accel_strobe(accel_strobe), .gyro_rate(gyro_rate),
      .accel_rate(accel_rate), .gyro_filter_used(gyro_filter_used), .gyro_fs_dps(gyro_fs_dps),
      .accel_fs_g(accel_fs_g), .selftest_en(selftest_en));

   sensor_source i_sensor_source (.sys_clk(sys_clk), .sensor_valid(sensor_valid),
      .sensor_chan(sensor_chan), .sensor_low_byte(sensor_low_byte),
      .frame_sync_in(frame_sync_in));

   // ==========================================================
   // reporting
   task automatic summarize;
      $display("counts: %0d compared, %0d failed", tests_run, failures);
      if (failures == 0 && tests_run > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic timeout;
      failures++;
      summarize();
   endtask : timeout
   // ==========================================================
   // register bus master
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      int n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 50) timeout();
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 50) timeout();
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      rd(a, d, r);
      check(d, exp);
   endtask : rd_chk
   // ==========================================================
   // fifo and rate helpers
   task automatic drain_chk(input logic [7:0] exp);
      int n;
      @(posedge sys_clk);
      drain_req <= 1'b1;
      @(posedge sys_clk);
      drain_req <= 1'b0;
      for (n = 0; n < 4; n++)
      begin
         @(posedge sys_clk);
         if (drain_valid) break;
      end
      if (n == 4) timeout();
      check(drain_data, exp);
   endtask : drain_chk
   task automatic wait_strobe(input logic acc);
      int n;
      for (n = 0; n < 3000; n++)
      begin
         @(posedge sys_clk);
         if (acc ? accel_strobe : sample_strobe) break;
      end
      if (n == 3000) timeout();
   endtask : wait_strobe
   task automatic period(input logic acc, output int q);
      wait_strobe(acc);
      wait_strobe(acc);
      q = 0;
      while (q < 2000)
      begin
         @(posedge sys_clk);
         q++;
         if (acc ? accel_strobe : sample_strobe) break;
      end
   endtask : period
   // ==========================================================
   // main sequence
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd_chk(A_CFG, 32'h0);
      rd_chk(A_GYR, 32'h0);
      rd_chk(A_ACC, 32'h0);
      rd_chk(A_AFL, 32'h0);
      rd(10'h3F0, d, r);
      check(r, RESP_SLVERR);
      $display("test reset values done");
      wr(A_CFG, 32'hFFFF_FFFF);
      rd_chk(A_CFG, 32'h7F);
      wr(A_GYR, 32'hFFFF_FFFF);
      rd_chk(A_GYR, 32'hFB);
      wr(A_ACC, 32'hFFFF_FFFF);
      rd_chk(A_ACC, 32'hF8);
      wr(A_AFL, 32'hFFFF_FFFF);
      rd_chk(A_AFL, 32'h0F);
      check(selftest_en, 32'h3F);
      $display("test access masks done");
      for (int i = 0; i < 4; i++)
      begin
         wr(A_GYR, i << 3);
         wr(A_ACC, i << 3);
         check(gyro_fs_dps, 250 << i);
         check(accel_fs_g, 2 << i);
      end
      $display("test ranges done");
      for (int i = 0; i < 7; i++)
      begin
         wr(A_CFG, t_cfg[i]);
         wr(A_GYR, t_byp[i]);
         check(gyro_rate, t_rate[i]);
         check(gyro_filter_used, t_used[i]);
      end
      wr(A_AFL, 32'h08);
      check(accel_rate, RATE_4K);
      period(1'b1, p);
      check(p, 30);
      wr(A_AFL, 32'h03);
      rd_chk(A_AFL, 32'h03);
      check(accel_rate, RATE_1K);
      period(1'b1, p);
      check(p, 60);
      $display("test filter rates done");
      wr(A_DIV, 32'h02);
      wr(A_CFG, 32'h03);
      period(1'b0, p);
      check(p, 180);
      wr(A_CFG, 32'h00);
      period(1'b0, p);
      check(p, 40);
      wr(A_DIV, 32'h00);
      $display("test divider done");
      wr(A_CFG, 32'h40);
      for (int i = 0; i < 17; i++) i_sensor_source.push(3'h0, 8'(2 * i));
      rd(A_STA, d, r);
      check(d[4:0], 16);
      for (int i = 0; i < 16; i++) drain_chk(8'(2 * i));
      wr(A_CFG, 32'h00);
      for (int i = 0; i < 17; i++) i_sensor_source.push(3'h0, 8'(8'h40 + 2 * i));
      for (int i = 1; i < 17; i++) drain_chk(8'(8'h40 + 2 * i));
      $display("test overflow policy done");
      wr(A_CFG, 32'h08);
      wait_strobe(1'b0);
      i_sensor_source.sync_pulse(2);
      wait_strobe(1'b0);
      i_sensor_source.push(3'h0, 8'h40);
      drain_chk(8'h41);
      i_sensor_source.push(3'h1, 8'h40);
      drain_chk(8'h40);
      wr(A_CFG, 32'h00);
      i_sensor_source.push(3'h0, 8'h40);
      drain_chk(8'h40);
      $display("test frame sync done");
      rstn <= 1'b0;
      @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd_chk(A_AFL, 32'h0);
      check(accel_fs_g, 32'h2);
      $display("test mid-run reset done");
      summarize();
   end
endmodule : testbench
`default_nettype wire
